// *** common/mscs_pkg.sv ***
// mscs_pkg: constants for the memory speed clock stretch block.
// assumes a 32-bit apb master and a 24-bit processor address bus.
package mscs_pkg;
   // register map: the printed offset is a word index, the bus sees bytes
   localparam logic [15:0] MSCS_SPEED_CTRL_INDEX  = 16'hDF41;
   localparam logic [17:0] MSCS_SPEED_CTRL_ADDR   = 18'h37D04;
   localparam logic [7:0]  MSCS_SPEED_CTRL_RESET  = 8'h00;
   // field positions in the speed control register
   localparam int          MSCS_BIT_OSC_RUN       = 0;
   localparam int          MSCS_BIT_SRC_FAST      = 1;
   localparam int          MSCS_BIT_RAM_EXT       = 2;
   localparam int          MSCS_BIT_CACHE_SPEED   = 3;
   localparam int          MSCS_BIT_LOW_SPEED     = 4;
   localparam int          MSCS_BIT_MID_SPEED     = 5;
   localparam int          MSCS_BIT_HIGH_SPEED    = 6;
   localparam int          MSCS_BIT_ONCHIP_SPEED  = 7;
   // address decode boundaries, bank byte and bank-zero offsets
   localparam logic [7:0]  MSCS_BANK_LOW_LAST     = 8'h3F;
   localparam logic [7:0]  MSCS_BANK_MID_LAST     = 8'hBF;
   localparam logic [15:0] MSCS_CACHE_INT_FIRST   = 16'h0200;
   localparam logic [15:0] MSCS_CACHE_LAST        = 16'h7FFF;
   localparam logic [15:0] MSCS_ONCHIP_FIRST      = 16'hDF00;
   localparam logic [15:0] MSCS_ONCHIP_LAST       = 16'hDFFF;
   // phase lengths in fast clock cycles, minus one
   localparam logic [1:0]  MSCS_FAST_HALF         = 2'h0;
   localparam logic [1:0]  MSCS_SLOW_HALF         = 2'h3;
   // region codes
   typedef enum logic [2:0] {
      MSCS_RGN_CACHE  = 3'h0,
      MSCS_RGN_LOW    = 3'h1,
      MSCS_RGN_MID    = 3'h2,
      MSCS_RGN_HIGH   = 3'h3,
      MSCS_RGN_ONCHIP = 3'h4
   } mscs_region_t;
endpackage

// *** common/mscs_dec_if.sv ***
// mscs_dec_if: carries an address to the region decoder and its verdict.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface mscs_dec_if;
   logic [23:0] addr;
   logic        ram_ext;
   logic [4:0]  speed_bits;
   logic        slow;
   logic [2:0]  region;
   modport requester (output addr, output ram_ext, output speed_bits,
                      input slow, input region);
   modport decoder   (input addr, input ram_ext, input speed_bits,
                      output slow, output region);
endinterface
`default_nettype wire

// *** logic/mscs_region_dec.sv ***
// mscs_region_dec: maps a 24-bit address onto a chip-select region.
// assumes speed bits are ordered cache, low, mid, high, on-chip.
`timescale 1ns/1ps
`default_nettype none
module mscs_region_dec (
   // decode request and verdict
   mscs_dec_if.decoder dec
);
   import mscs_pkg::*;

   // every address lands in exactly one region
   always_comb begin
      logic [7:0]  bank;
      logic [15:0] ofs;
      bank = dec.addr[23:16];
      ofs  = dec.addr[15:0];
      if (bank > MSCS_BANK_MID_LAST) begin
         dec.region = MSCS_RGN_HIGH;
      end else if (bank > MSCS_BANK_LOW_LAST) begin
         dec.region = MSCS_RGN_MID;
      end else if (bank != 8'h00) begin
         dec.region = MSCS_RGN_LOW;
      end else if (ofs <= MSCS_CACHE_LAST &&
                   (dec.ram_ext || ofs >= MSCS_CACHE_INT_FIRST)) begin
         dec.region = MSCS_RGN_CACHE;  // window follows ram select
      end else if (ofs < MSCS_CACHE_INT_FIRST ||
                   (ofs >= MSCS_ONCHIP_FIRST && ofs <= MSCS_ONCHIP_LAST)) begin
         dec.region = MSCS_RGN_ONCHIP;
      end else begin
         dec.region = MSCS_RGN_LOW;
      end
      // a clear bit marks the region slow
      dec.slow = ~dec.speed_bits[dec.region];
   end
endmodule
`default_nettype wire

// *** logic/mscs_clock_stretch.sv ***
// mscs_clock_stretch: speed control register and cpu phase clock stretcher.
// assumes an apb master and a fast clock domain equal to i_ref_clk; the
// processor phase clock is produced as an output level, not a real clock.
//
// Behaviour
// - fast-rate memory runs unstretched as cache
// - slow region access slows the phase clock
// - stretch both low and high phases
// - slowdown decided by address region and speed register
// - bit 0 stops or starts fast oscillator
// - bit 1 selects slow clock or fast
// - per-region speed bit, zero means slow
// - whole 16 Mbyte space decodes to regions
// - ram select bit moves cache window start
// - speed register resets to zero
`timescale 1ns/1ps
`default_nettype none
module mscs_clock_stretch (
   // clock, reset, enable
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_clk_en,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [17:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic [31:0]      o_prdata,
   // processor side
   input  wire logic [23:0] i_cpu_addr,
   input  wire logic        i_low_freq_clk,
   // clock outputs
   output logic             o_cpu_phase_clock,
   output logic             o_fast_osc_run,
   output logic             o_slow_access
);
   import mscs_pkg::*;

   typedef struct packed {
      logic [7:0]  speed_ctrl;
      logic [1:0]  half_cnt;
      logic [1:0]  half_len;
      logic        phase;
      logic        slow;
      logic [31:0] rdata;
      logic        lf_s1;
      logic        lf_s2;
   } mscs_state_t;

   mscs_state_t st_q;
   mscs_state_t st_d;
   mscs_dec_if  dec ();

   // register fields feed the decoder
   assign dec.addr       = i_cpu_addr;
   assign dec.ram_ext    = st_q.speed_ctrl[MSCS_BIT_RAM_EXT];
   assign dec.speed_bits = st_q.speed_ctrl[MSCS_BIT_ONCHIP_SPEED:
                                           MSCS_BIT_CACHE_SPEED];

   mscs_region_dec u_dec (
      .dec (dec)
   );

   logic wr_hit;
   logic rd_hit;
   // zero-wait slave; unmapped words read zero with no error
   assign wr_hit = i_psel & i_penable & i_pwrite &
                   (i_paddr == MSCS_SPEED_CTRL_ADDR);
   assign rd_hit = i_psel & ~i_penable & ~i_pwrite &
                   (i_paddr == MSCS_SPEED_CTRL_ADDR);
   assign o_pready  = 1'b1;
   assign o_pslverr = 1'b0;

   // next-state: register write, divider, phase toggle
   always_comb begin
      st_d = st_q;
      st_d.lf_s1 = i_low_freq_clk;
      st_d.lf_s2 = st_q.lf_s1;
      if (wr_hit) begin
         st_d.speed_ctrl = i_pwdata[7:0];  // register bits and cpu address steer
      end
      if (i_psel & ~i_penable) begin
         st_d.rdata = rd_hit ? {24'h000000, st_q.speed_ctrl} : 32'h00000000;
      end
      if (st_q.speed_ctrl[MSCS_BIT_SRC_FAST]) begin
         // fast source only ticks while the oscillator runs
         if (st_q.speed_ctrl[MSCS_BIT_OSC_RUN]) begin
            if (st_q.half_cnt == st_q.half_len) begin
               st_d.phase    = ~st_q.phase;
               st_d.half_cnt = 2'h0;
               // divisor latched at the boundary only
               if (st_q.phase) begin
                  st_d.slow     = dec.slow;
                  // cache at fast rate runs unstretched
                  // both halves stretched by the same length
                  st_d.half_len = dec.slow ? MSCS_SLOW_HALF : MSCS_FAST_HALF;
               end
            end else begin
               st_d.half_cnt = st_q.half_cnt + 2'h1;
            end
         end
      end else begin
         // low-frequency source drives the phase through the two-flop synchronizer
         st_d.phase    = st_q.lf_s2;
         st_d.half_cnt = 2'h0;
         // nothing is stretched while the slow pin clocks the cpu
         st_d.slow     = 1'b0;
      end
   end

   // state register, frozen by the clock enable
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q            <= '0;
         st_q.speed_ctrl <= MSCS_SPEED_CTRL_RESET;
      end else if (i_clk_en) begin
         st_q <= st_d;
      end
   end

   assign o_prdata          = st_q.rdata;
   assign o_cpu_phase_clock = st_q.phase;
   assign o_fast_osc_run    = st_q.speed_ctrl[MSCS_BIT_OSC_RUN];
   assign o_slow_access     = st_q.slow;
endmodule
`default_nettype wire

// *** verif/mscs_mem_model.sv ***
// mscs_mem_model: far-side stand-in that drives the slow clock pin
// assumes the fast clock runs freely
`timescale 1ns/1ps
`default_nettype none
module mscs_mem_model (
   input  wire logic i_ref_clk,
   input  wire logic i_reset_n,
   output logic      o_low_freq_clk
);
   logic [2:0] div_q;
   // toggles every 5 cycles so it never lines up with the phase clock
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         div_q <= 3'h0;
         o_low_freq_clk <= 1'b0;
      end else begin
         div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
         if (div_q == 3'h4) o_low_freq_clk <= ~o_low_freq_clk;
      end
   end
endmodule
`default_nettype wire

// *** verif/mscs_clock_stretch_sva.sv ***
// mscs_clock_stretch_sva: port checks of the clock stretcher
// assumes i_clk_en is held high
`timescale 1ns/1ps
`default_nettype none
module mscs_chk (
   input wire logic        i_ref_clk,
   input wire logic        i_reset_n,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [17:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic        o_pready,
   input wire logic [31:0] o_prdata,
   input wire logic        i_low_freq_clk,
   input wire logic        o_cpu_phase_clock,
   input wire logic        o_fast_osc_run,
   input wire logic        o_slow_access
);
   import mscs_pkg::*;
   logic [7:0] ctl_q;
   logic       acc, hit, fm;
   assign acc = i_psel && i_penable && o_pready;
   assign hit = i_paddr == MSCS_SPEED_CTRL_ADDR;
   assign fm = ctl_q[1:0] == 2'b11;
   // shadow of the speed register, rebuilt from bus traffic alone
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) ctl_q <= 8'h00;
      else if (acc && i_pwrite && hit) ctl_q <= i_pwdata[7:0];
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   sequence s_slow_half;
      $stable(o_cpu_phase_clock)[*3] ##1 $changed(o_cpu_phase_clock);
   endsequence
   sequence s_fast_mid;
      fm && $past(fm) && $rose(o_cpu_phase_clock);
   endsequence
   AST_OSC_RUN: assert property (o_fast_osc_run == ctl_q[0])
      else $error("osc run");
   AST_READ_REG: assert property (acc && !i_pwrite && hit |->
      o_prdata == {24'h0, ctl_q}) else $error("read reg");
   AST_READ_HOLE: assert property (acc && !i_pwrite && !hit |->
      o_prdata == 32'h0) else $error("read hole");
   AST_SLOW_STRETCH: assert property (s_fast_mid and o_slow_access
      |=> s_slow_half) else $error("slow half");
   AST_FAST_PLAIN: assert property (s_fast_mid and !o_slow_access
      |=> $fell(o_cpu_phase_clock)) else $error("fast half");
   AST_HOLD_REGION: assert property (s_fast_mid
      |-> $stable(o_slow_access)) else $error("region swap");
   AST_FREEZE: assert property (ctl_q[1:0] == 2'b10 &&
      $past(ctl_q[1:0]) == 2'b10 |-> $stable(o_cpu_phase_clock))
      else $error("freeze");
   AST_LOW_CLK: assert property ((!ctl_q[1])[*4] |->
      o_cpu_phase_clock == $past(i_low_freq_clk, 3)) else $error("low clk");
endmodule
bind mscs_clock_stretch mscs_chk u_chk (.i_ref_clk, .i_reset_n, .i_psel,
   .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata,
   .i_low_freq_clk, .o_cpu_phase_clock, .o_fast_osc_run, .o_slow_access);
`default_nettype wire

// *** verif/test_memory_speed_clock_stretch.sv ***
// test_memory_speed_clock_stretch: random and corner region checks
// assumes the checker is bound to the design
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_memory_speed_clock_stretch;
   import mscs_pkg::*;
   logic        i_ref_clk = 0, i_reset_n = 0, psel = 0, pen = 0, pwr = 0;
   logic [17:0] paddr = 0;
   logic        phase, ph;
   int          hl;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [23:0] cpu = 0;
   logic [7:0]  ctl;
   logic        lfc, pready, slow, osc;
   int          fails = 0, compares = 0, cyc = 0, seed = 32'hf5be238d;
   logic [23:0] corner [10] = '{24'h000100, 24'h000200, 24'h007FFF,
      24'h008000, 24'h00DF41, 24'h010000, 24'h3FFFFF, 24'h400000,
      24'hBFFFFF, 24'hC00000};
   always #5 i_ref_clk = ~i_ref_clk;
   mscs_mem_model u_mem (.i_ref_clk, .i_reset_n, .o_low_freq_clk(lfc));
   mscs_clock_stretch dut (.i_ref_clk, .i_reset_n, .i_clk_en(1'b1),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(), .o_prdata(prdata),
      .i_cpu_addr(cpu), .i_low_freq_clk(lfc), .o_cpu_phase_clock(phase),
      .o_fast_osc_run(osc), .o_slow_access(slow));
   task automatic final_report();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one apb transfer; request held until pready is seen high or 20 edges pass
   task automatic apb(input logic w, input logic [31:0] d);
      int n = 0;
      psel <= 1'b1;
      pwr <= w;
      pwdata <= d;
      @(posedge i_ref_clk);
      pen <= 1'b1;
      do @(posedge i_ref_clk); while (pready !== 1'b1 && ++n < 20);
      rd = prdata;
      psel <= 1'b0;
      pen <= 1'b0;
      // idle edge so a following call never rewrites psel in this step
      @(posedge i_ref_clk);
   endtask
   // region of an address, then its speed bit decides the stretch
   function automatic logic exp_slow(logic [23:0] a, logic [7:0] c);
      int b = MSCS_BIT_LOW_SPEED;
      if (a[23:16] > MSCS_BANK_MID_LAST) b = MSCS_BIT_HIGH_SPEED;
      else if (a[23:16] > MSCS_BANK_LOW_LAST) b = MSCS_BIT_MID_SPEED;
      else if (a[23:16] != 8'h00 || a[15:0] > MSCS_CACHE_LAST) b = b;
      else if (a[15:0] >= MSCS_CACHE_INT_FIRST || c[2]) b = 3;
      else b = MSCS_BIT_ONCHIP_SPEED;
      if (a[23:8] == 16'h00DF) b = MSCS_BIT_ONCHIP_SPEED;
      return c[1:0] == 2'b11 && !c[b];
   endfunction
   always @(posedge i_ref_clk) if (++cyc > 20000) begin
      fails++;
      final_report();
   end
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      paddr <= MSCS_SPEED_CTRL_ADDR;
      @(posedge i_ref_clk);
      apb(0, 0);
      `CHK(rd, 32'h0)
      for (int i = 0; i < 80; i++) begin
         ctl = 8'($random(seed)) | 8'h03;
         ctl[2] = (i < 20) ? i[0] : ctl[2];
         apb(1, {24'h0, ctl});
         cpu <= (i < 20) ? corner[i / 2] : 24'($random(seed));
         repeat (14) @(posedge i_ref_clk);
         // sample on the falling edge, away from the launching edge
         @(negedge i_ref_clk);
         `CHK(slow, exp_slow(cpu, ctl))
         ph = phase;
         hl = 0;
         while (phase === ph && hl < 12) begin
            @(negedge i_ref_clk);
            hl++;
         end
         ph = phase;
         hl = 0;
         while (phase === ph && hl < 12) begin
            @(negedge i_ref_clk);
            hl++;
         end
         `CHK(hl, exp_slow(cpu, ctl) ? 4 : 1)
         @(posedge i_ref_clk);
         paddr <= (i % 8 == 0) ? 18'h37D00 : MSCS_SPEED_CTRL_ADDR;
         apb(0, 0);
         `CHK(rd, (i % 8 == 0) ? 32'h0 : {24'h0, ctl})
         paddr <= MSCS_SPEED_CTRL_ADDR;
      end
      apb(1, 32'h2);
      repeat (20) @(posedge i_ref_clk);
      `CHK(osc, 1'b0)
      apb(1, 32'h0);
      repeat (40) @(posedge i_ref_clk);
      `CHK(slow, 1'b0)
      final_report();
   end
endmodule
`default_nettype wire
